//--- rtl/ifl_pkg.sv
// Constants and shared types for the interrupt and fault logger
package ifl_pkg;

   // Memory-mapped register addresses
   localparam logic [31:0] ADDR_PENDING     = 32'h1801_0002;
   localparam logic [31:0] ADDR_ENABLE      = 32'h1802_0002;
   localparam logic [31:0] ADDR_FAULT_ADDR  = 32'h1803_0000;
   localparam logic [31:0] ADDR_FAULT_CAUSE = 32'h1804_0002;
   localparam logic [31:0] ADDR_TMR0_ACK    = 32'h1805_0003;
   localparam logic [31:0] ADDR_TMR1_ACK    = 32'h1806_0003;

   // Reset values
   localparam logic [15:0] ENABLE_RESET     = 16'h0000;
   localparam logic [15:0] CAUSE_RESET      = 16'h0000;
   localparam logic [31:0] FAULT_ADDR_RESET = 32'h0000_0000;

   // Level-0 source layout
   localparam int EXP_IRQ_LSB   = 0;
   localparam int EXP_IRQ_COUNT = 11;
   localparam int LOCAL_IRQ_LSB = 11;

   // Fault cause field positions
   localparam int CAUSE_PAR_LSB  = 0;
   localparam int CAUSE_SIZE_LSB = 4;
   localparam int CAUSE_READ_BIT = 6;
   localparam int CAUSE_TOUT_BIT = 7;

   // Bus hold limit before a forced release
   localparam int CLK_PERIOD_NS   = 20;
   localparam int BUS_HOLD_MAX_US = 16;
   localparam int BUS_HOLD_CYCLES = (BUS_HOLD_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int HOLD_CNT_W      = 10;

   // Host access request and answer
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [15:0] wdata;
   } ifl_req_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } ifl_rsp_s;

   // Fault report from memory and expansion bus
   typedef struct packed {
      logic       valid;
      logic       cpu_read;
      logic       read;
      logic [3:0] parity_n;
      logic [1:0] size;
   } ifl_fault_s;

   // State of the fault capture module
   typedef struct packed {
      logic        pend;
      logic [31:0] addr;
      logic [15:0] cause;
   } ifl_log_s;

   // State of the top module
   typedef struct packed {
      logic [15:0]           pending;
      logic [15:0]           enable;
      logic [15:0]           caught;
      logic                  irq0;
      logic                  irq3;
      logic                  ser_prev;
      logic                  ser_pend;
      logic [1:0]            tmr_prev;
      logic [1:0]            tmr_pend;
      logic [HOLD_CNT_W-1:0] hold_cnt;
      logic                  release_bus;
      ifl_rsp_s              rsp;
   } ifl_state_s;

endpackage

//--- rtl/ifl_fault_log.sv
// Fault address and fault cause capture
`timescale 1ns/100ps

module ifl_fault_log (
   // Clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst,
   input  wire logic             i_ce,
   // Fault capture
   input  wire logic [31:0]      i_mem_addr,
   input  wire ifl_pkg::ifl_fault_s i_fault,
   input  wire logic             i_timeout,
   input  wire logic             i_clear,
   // Captured record
   output logic                  o_pend,
   output logic [31:0]           o_addr,
   output logic [15:0]           o_cause
);

   ifl_pkg::ifl_log_s st;
   ifl_pkg::ifl_log_s next_st;
   logic              event_hit;

   // Faults on processor reads are answered elsewhere, not logged
   assign event_hit = (i_fault.valid || i_timeout) && !i_fault.cpu_read;

   // Clear first, then a new fault, so a fault in the clear cycle wins
   always_comb begin
      next_st = st;
      if (i_clear) begin
         next_st.pend  = 1'b0;
         next_st.cause = ifl_pkg::CAUSE_RESET;
      end
      if (!next_st.pend) begin
         next_st.addr = i_mem_addr;
         if (event_hit) begin
            next_st.pend = 1'b1;
            next_st.cause = ifl_pkg::CAUSE_RESET;
            // Parity lanes are meaningless on timeout, forced to all ones
            next_st.cause[ifl_pkg::CAUSE_PAR_LSB +: 4] =
               i_timeout ? 4'hf : i_fault.parity_n;
            next_st.cause[ifl_pkg::CAUSE_SIZE_LSB +: 2] = ~i_fault.size;
            next_st.cause[ifl_pkg::CAUSE_READ_BIT] = i_fault.read;
            next_st.cause[ifl_pkg::CAUSE_TOUT_BIT] = i_timeout;
         end
      end
   end

   // Record holds until the address register is read
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         st.pend  <= 1'b0;
         st.addr  <= ifl_pkg::FAULT_ADDR_RESET;
         st.cause <= ifl_pkg::CAUSE_RESET;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_pend  = st.pend;
   assign o_addr  = st.addr;
   assign o_cause = st.cause;

endmodule

//--- rtl/ifl_interrupt_logger.sv
// Interrupt aggregation and bus fault logging top level
`timescale 1ns/100ps

module ifl_interrupt_logger (
   // Clock, reset, clock enable
   input  wire logic                i_clk_sys,
   input  wire logic                i_rst,
   input  wire logic                i_ce,
   // Host register access
   input  wire ifl_pkg::ifl_req_s   i_req,
   output ifl_pkg::ifl_rsp_s        o_rsp,
   // Level-0 sources
   input  wire logic [10:0]         i_exp_irq,
   input  wire logic [4:0]          i_local_irq,
   // Other interrupt sources and the serial status access strobe
   input  wire logic                i_serial_ctrl_first_irq,
   input  wire logic                i_serial_ctrl_second_irq,
   input  wire logic                i_serial_status_access,
   input  wire logic                i_interval_timer_first_irq,
   input  wire logic                i_interval_timer_second_irq,
   input  wire logic                i_coproc_irq,
   // Memory bus observation
   input  wire logic [31:0]         i_mem_addr,
   input  wire logic                i_mem_busy,
   input  wire ifl_pkg::ifl_fault_s i_fault,
   output logic                     o_bus_release,
   // Interrupt lines to the processor
   output logic                     o_irq_level_zero_n,
   output logic                     o_irq_level_one_n,
   output logic                     o_irq_level_two_n,
   output logic                     o_irq_level_three_n,
   output logic                     o_irq_level_four_n,
   output logic                     o_irq_level_five_n
);

   ifl_pkg::ifl_state_s st;
   ifl_pkg::ifl_state_s next_st;

   logic [15:0] src_live;
   logic [1:0]  tmr_live;
   logic        ser_live;
   logic        hit_pending;
   logic        hit_enable;
   logic        hit_faddr;
   logic        hit_fcause;
   logic        hit_tmr0;
   logic        hit_tmr1;
   logic        rd_strobe;
   logic        wr_strobe;
   logic        faddr_read;
   logic        timeout_evt;
   logic        log_pend;
   logic [31:0] log_addr;
   logic [15:0] log_cause;

   // Exact address match; used by every register decode
   function automatic logic ifl_hit(input logic [31:0] a, input logic [31:0] reg_addr);
      ifl_hit = (a == reg_addr);
   endfunction

   // Source vector: expansion requests low, local devices above
   assign src_live[ifl_pkg::EXP_IRQ_LSB +: ifl_pkg::EXP_IRQ_COUNT] = i_exp_irq;
   assign src_live[15:ifl_pkg::LOCAL_IRQ_LSB] = i_local_irq;
   assign tmr_live = {i_interval_timer_second_irq, i_interval_timer_first_irq};
   assign ser_live = i_serial_ctrl_first_irq | i_serial_ctrl_second_irq;

   // Strobes and address decode
   assign rd_strobe   = i_req.valid && !i_req.write;
   assign wr_strobe   = i_req.valid && i_req.write;
   assign hit_pending = ifl_hit(i_req.addr, ifl_pkg::ADDR_PENDING);
   assign hit_enable  = ifl_hit(i_req.addr, ifl_pkg::ADDR_ENABLE);
   assign hit_faddr   = ifl_hit(i_req.addr, ifl_pkg::ADDR_FAULT_ADDR);
   assign hit_fcause  = ifl_hit(i_req.addr, ifl_pkg::ADDR_FAULT_CAUSE);
   assign hit_tmr0    = ifl_hit(i_req.addr, ifl_pkg::ADDR_TMR0_ACK);
   assign hit_tmr1    = ifl_hit(i_req.addr, ifl_pkg::ADDR_TMR1_ACK);
   assign faddr_read  = rd_strobe && hit_faddr;

   // Bus hold limit reached this cycle
   assign timeout_evt = i_mem_busy &&
      (st.hold_cnt == ifl_pkg::HOLD_CNT_W'(ifl_pkg::BUS_HOLD_CYCLES - 1));

   // Fault capture: address latch, cause record, level-5 pending
   ifl_fault_log u_fault_log (
      .i_clk_sys  (i_clk_sys),
      .i_rst      (i_rst),
      .i_ce       (i_ce),
      .i_mem_addr (i_mem_addr),
      .i_fault    (i_fault),
      .i_timeout  (timeout_evt),
      .i_clear    (faddr_read),
      .o_pend     (log_pend),
      .o_addr     (log_addr),
      .o_cause    (log_cause)
   );

   // Next-state logic for interrupts, counters and register answers
   always_comb begin
      next_st = st;

      // Pending mirrors live levels, no latching
      next_st.pending = src_live;

      // A source caught while enabled stays caught until it withdraws,
      // so clearing its enable in the same cycle does not lose it
      next_st.caught = (st.caught | (src_live & st.enable)) & src_live;
      next_st.irq0 = |(src_live & st.enable) | |next_st.caught;

      // Enable register write, many bits at once
      if (wr_strobe && hit_enable) begin
         next_st.enable = i_req.wdata;
      end

      // Serial level: edge sets, host access clears, set wins
      next_st.ser_prev = ser_live;
      if (i_serial_status_access) begin
         next_st.ser_pend = 1'b0;
      end
      if (ser_live && !st.ser_prev) begin
         next_st.ser_pend = 1'b1;
      end

      // Timer levels: edge sets, acknowledge read clears, set wins
      next_st.tmr_prev = tmr_live;
      if (rd_strobe && hit_tmr0) begin
         next_st.tmr_pend[0] = 1'b0;
      end
      if (rd_strobe && hit_tmr1) begin
         next_st.tmr_pend[1] = 1'b0;
      end
      next_st.tmr_pend = next_st.tmr_pend | (tmr_live & ~st.tmr_prev);

      // Coprocessor level, nothing else shares it
      next_st.irq3 = i_coproc_irq;

      // Bus hold watchdog; restarts when the bus is let go
      next_st.release_bus = timeout_evt;
      if (!i_mem_busy || timeout_evt) begin
         next_st.hold_cnt = '0;
      end else begin
         next_st.hold_cnt = st.hold_cnt + 1'b1;
      end

      // Register read answer, one cycle after the request
      next_st.rsp.ack   = i_req.valid;
      next_st.rsp.rdata = 32'h0000_0000;
      if (rd_strobe) begin
         if (hit_pending) begin
            next_st.rsp.rdata[15:0] = st.pending;
         end else if (hit_enable) begin
            next_st.rsp.rdata[15:0] = st.enable;
         end else if (hit_faddr) begin
            next_st.rsp.rdata = log_addr;
         end else if (hit_fcause) begin
            next_st.rsp.rdata[15:0] = log_cause;
         end else begin
            // Timer acknowledges and unmapped addresses read zero
            next_st.rsp.rdata = 32'h0000_0000;
         end
      end
   end

   // State register; clock enable freezes everything
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         st.pending     <= '0;
         st.enable      <= ifl_pkg::ENABLE_RESET;
         st.caught      <= '0;
         st.irq0        <= 1'b0;
         st.irq3        <= 1'b0;
         st.ser_prev    <= 1'b0;
         st.ser_pend    <= 1'b0;
         st.tmr_prev    <= 2'h0;
         st.tmr_pend    <= 2'h0;
         st.hold_cnt    <= '0;
         st.release_bus <= 1'b0;
         st.rsp         <= '0;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   // Outputs; lines are active low, inverted from registered levels
   assign o_rsp               = st.rsp;
   assign o_bus_release       = st.release_bus;
   assign o_irq_level_zero_n  = ~st.irq0;
   assign o_irq_level_one_n   = ~st.ser_pend;
   assign o_irq_level_two_n   = ~st.tmr_pend[0];
   assign o_irq_level_three_n = ~st.irq3;
   assign o_irq_level_four_n  = ~st.tmr_pend[1];
   assign o_irq_level_five_n  = ~log_pend;

endmodule

//--- bench/ifl_assertions.sv
// Port-level assertions for the interrupt and fault logger
`timescale 1ns/100ps
module ifl_assertions (
   // Clock and reset
   input wire logic                i_clk_sys,
   input wire logic                i_rst,
   input wire logic                i_ce,
   // Watched inputs
   input wire ifl_pkg::ifl_req_s   i_req,
   input wire logic [10:0]         i_exp_irq,
   input wire logic [4:0]          i_local_irq,
   input wire logic                i_serial_ctrl_first_irq,
   input wire logic                i_serial_ctrl_second_irq,
   input wire logic                i_serial_status_access,
   input wire logic                i_interval_timer_first_irq,
   input wire logic                i_interval_timer_second_irq,
   input wire logic                i_coproc_irq,
   input wire logic                i_mem_busy,
   input wire ifl_pkg::ifl_fault_s i_fault,
   // Watched outputs
   input wire ifl_pkg::ifl_rsp_s   o_rsp,
   input wire logic                o_bus_release,
   input wire logic                o_irq_level_zero_n,
   input wire logic                o_irq_level_one_n,
   input wire logic                o_irq_level_two_n,
   input wire logic                o_irq_level_three_n,
   input wire logic                o_irq_level_four_n,
   input wire logic                o_irq_level_five_n
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst || !i_ce);
   // Decodes shared by several checks
   wire rd  = i_req.valid && !i_req.write;
   wire ser = i_serial_ctrl_first_irq || i_serial_ctrl_second_irq;
   wire bad = i_fault.valid && !i_fault.cpu_read;
   AST_ACK: assert property (i_req.valid |=> o_rsp.ack) else $error("no answer");
   AST_RST_IRQ0: assert property ($past(i_rst) |-> o_irq_level_zero_n [*2])
      else $error("level 0 after reset");
   AST_IRQ0_IDLE: assert property ((i_exp_irq == 11'h000 && i_local_irq == 5'h00) [*4]
      |-> o_irq_level_zero_n) else $error("level 0 without source");
   AST_IRQ3: assert property (!$past(i_rst) |-> o_irq_level_three_n == !$past(i_coproc_irq))
      else $error("level 3 mismatch");
   AST_IRQ1_SET: assert property ($rose(ser) |=> !o_irq_level_one_n) else $error("level 1");
   AST_IRQ1_CLR: assert property (i_serial_status_access && !$rose(ser) |=> o_irq_level_one_n)
      else $error("level 1 not released");
   AST_TMR0: assert property ($rose(i_interval_timer_first_irq) |=> !o_irq_level_two_n)
      else $error("level 2 not set");
   AST_TMR1_ACK: assert property (rd && i_req.addr == ifl_pkg::ADDR_TMR1_ACK
      && !$rose(i_interval_timer_second_irq) |=> o_irq_level_four_n) else $error("level 4 kept");
   AST_FAULT: assert property (bad && o_irq_level_five_n |=> !o_irq_level_five_n)
      else $error("fault missed");
   AST_CPU_RD: assert property (i_fault.valid && i_fault.cpu_read && !i_mem_busy
      && o_irq_level_five_n |=> o_irq_level_five_n) else $error("cpu read fault logged");
   AST_FAR_CLR: assert property (rd && i_req.addr == ifl_pkg::ADDR_FAULT_ADDR && !bad
      && !i_mem_busy |=> o_irq_level_five_n) else $error("level 5 kept");
   // Main scenarios reached
   cover property (!o_irq_level_zero_n);
   cover property (!o_irq_level_five_n);
   cover property (o_bus_release);
endmodule

bind ifl_interrupt_logger ifl_assertions u_ast (.*);

//--- bench/ifl_host_model.sv
// Host processor model issuing register accesses
`timescale 1ns/100ps
module ifl_host_model (
   // Clock
   input  wire logic              i_clk_sys,
   // Register port
   input  wire ifl_pkg::ifl_rsp_s i_rsp,
   output ifl_pkg::ifl_req_s      o_req
);
   initial o_req = '0;
   // One-cycle request; a missing answer yields unknown data
   task automatic acc(input logic wr, input logic [31:0] a, input logic [15:0] wd,
                      output logic [31:0] rd);
      @(posedge i_clk_sys);
      o_req <= '{1'b1, wr, a, wd};
      @(posedge i_clk_sys);
      o_req <= '0;
      @(posedge i_clk_sys);
      rd = i_rsp.ack ? i_rsp.rdata : 'x;
   endtask
endmodule

//--- bench/tb_interrupt_and_fault_logger.sv
// Self-checking bench for the interrupt and fault logger
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
   $display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end
module tb_interrupt_and_fault_logger;
   logic                i_clk_sys = 1'b0;
   logic                i_rst = 1'b1;
   logic                i_ce = 1'b1;
   ifl_pkg::ifl_req_s   i_req;
   ifl_pkg::ifl_rsp_s   o_rsp;
   logic [10:0]         i_exp_irq = 11'h000;
   logic [4:0]          i_local_irq = 5'h00;
   logic                i_serial_ctrl_first_irq = 1'b0;
   logic                i_serial_ctrl_second_irq = 1'b0;
   logic                i_serial_status_access = 1'b0;
   logic                i_interval_timer_first_irq = 1'b0;
   logic                i_interval_timer_second_irq = 1'b0;
   logic                i_coproc_irq = 1'b0;
   logic [31:0]         i_mem_addr = 32'h0000_0000;
   logic                i_mem_busy = 1'b0;
   ifl_pkg::ifl_fault_s i_fault = '0;
   logic                o_bus_release, o_irq_level_zero_n, o_irq_level_one_n;
   logic                o_irq_level_two_n, o_irq_level_three_n;
   logic                o_irq_level_four_n, o_irq_level_five_n;
   int                  err_total = 0;
   int                  num_checks = 0;
   int                  cyc = 0;
   logic [31:0]         r;

   ifl_interrupt_logger dut (.*);
   ifl_host_model host (.i_clk_sys(i_clk_sys), .i_rsp(o_rsp), .o_req(i_req));

   // 50 MHz clock
   always #10 i_clk_sys = ~i_clk_sys;

   task automatic cyc_n(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask

   task automatic t_reset();
      `CHK({o_irq_level_zero_n, o_irq_level_one_n, o_irq_level_two_n, o_irq_level_three_n,
            o_irq_level_four_n, o_irq_level_five_n}, 6'h3f)
      host.acc(1'b0, ifl_pkg::ADDR_ENABLE, 16'h0000, r);
      `CHK(r, 32'h0000_0000)
      host.acc(1'b1, ifl_pkg::ADDR_PENDING, 16'hffff, r);
      host.acc(1'b0, ifl_pkg::ADDR_PENDING, 16'h0000, r);
      `CHK(r, 32'h0000_0000)
      host.acc(1'b0, 32'h1800_0004, 16'h0000, r);
      `CHK(r, 32'h0000_0000)
      $display("test reset done");
   endtask

   task automatic t_level0();
      host.acc(1'b1, ifl_pkg::ADDR_ENABLE, 16'h0401, r);
      i_local_irq <= 5'h02;
      cyc_n(3);
      `CHK(o_irq_level_zero_n, 1'b1)
      i_exp_irq <= 11'h400;
      cyc_n(3);
      `CHK(o_irq_level_zero_n, 1'b0)
      host.acc(1'b0, ifl_pkg::ADDR_PENDING, 16'h0000, r);
      `CHK(r, 32'h0000_1400)
      host.acc(1'b1, ifl_pkg::ADDR_ENABLE, 16'h0000, r);
      cyc_n(2);
      `CHK(o_irq_level_zero_n, 1'b0)
      i_exp_irq <= 11'h000;
      i_local_irq <= 5'h00;
      cyc_n(4);
      `CHK(o_irq_level_zero_n, 1'b1)
      host.acc(1'b0, ifl_pkg::ADDR_PENDING, 16'h0000, r);
      `CHK(r, 32'h0000_0000)
      $display("test level0 done");
   endtask

   task automatic t_serial();
      for (int k = 0; k < 2; k++) begin
         {i_serial_ctrl_second_irq, i_serial_ctrl_first_irq} <= 2'h0;
         cyc_n(1);
         {i_serial_ctrl_second_irq, i_serial_ctrl_first_irq} <= k ? 2'h2 : 2'h1;
         cyc_n(2);
         `CHK(o_irq_level_one_n, 1'b0)
         i_serial_status_access <= 1'b1;
         cyc_n(1);
         i_serial_status_access <= 1'b0;
         cyc_n(1);
         `CHK(o_irq_level_one_n, 1'b1)
      end
      $display("test serial done");
   endtask

   task automatic t_timers();
      for (int k = 0; k < 2; k++) begin
         {i_interval_timer_second_irq, i_interval_timer_first_irq} <= k ? 2'h2 : 2'h1;
         cyc_n(1);
         {i_interval_timer_second_irq, i_interval_timer_first_irq} <= 2'h0;
         cyc_n(1);
         `CHK({o_irq_level_four_n, o_irq_level_two_n}, k ? 2'h1 : 2'h2)
         host.acc(1'b0, k ? ifl_pkg::ADDR_TMR1_ACK : ifl_pkg::ADDR_TMR0_ACK, 16'h0000, r);
         `CHK(r, 32'h0000_0000)
         `CHK({o_irq_level_four_n, o_irq_level_two_n}, 2'h3)
      end
      $display("test timers done");
   endtask

   task automatic t_coproc();
      i_coproc_irq <= 1'b1;
      cyc_n(2);
      `CHK({o_irq_level_three_n, o_irq_level_zero_n, o_irq_level_five_n}, 3'h3)
      i_coproc_irq <= 1'b0;
      cyc_n(2);
      `CHK(o_irq_level_three_n, 1'b1)
      $display("test coproc done");
   endtask

   task automatic t_fault();
      logic [31:0] a;
      for (int k = 0; k < 2; k++) begin
         a = k ? 32'h0280_0004 : 32'h0000_1230;
         i_mem_addr <= a;
         i_fault <= '{1'b1, 1'b1, 1'b0, 4'h7, 2'h1};
         cyc_n(1);
         i_fault <= k ? '{1'b1, 1'b0, 1'b1, 4'he, 2'h2} : '{1'b1, 1'b0, 1'b0, 4'h7, 2'h1};
         cyc_n(1);
         `CHK(o_irq_level_five_n, 1'b1)
         i_fault <= '{1'b1, 1'b0, 1'b0, 4'h0, 2'h0};
         i_mem_addr <= 32'hffff_fffc;
         cyc_n(1);
         `CHK(o_irq_level_five_n, 1'b0)
         i_fault <= '0;
         host.acc(1'b0, ifl_pkg::ADDR_FAULT_CAUSE, 16'h0000, r);
         `CHK(r, k ? 32'h0000_005e : 32'h0000_0027)
         host.acc(1'b0, ifl_pkg::ADDR_FAULT_ADDR, 16'h0000, r);
         `CHK(r, a)
         `CHK(o_irq_level_five_n, 1'b1)
         host.acc(1'b0, ifl_pkg::ADDR_FAULT_CAUSE, 16'h0000, r);
         `CHK(r, 32'h0000_0000)
      end
      $display("test fault done");
   endtask

   task automatic t_timeout();
      int n;
      n = 0;
      i_mem_busy <= 1'b1;
      do begin
         cyc_n(1);
         n++;
      end while (o_bus_release !== 1'b1 && n < 900);
      `CHK(n >= 801 && n <= 802, 1'b1)
      i_mem_busy <= 1'b0;
      cyc_n(1);
      `CHK(o_irq_level_five_n, 1'b0)
      host.acc(1'b0, ifl_pkg::ADDR_FAULT_CAUSE, 16'h0000, r);
      `CHK(r, 32'h0000_00bf)
      host.acc(1'b0, ifl_pkg::ADDR_FAULT_ADDR, 16'h0000, r);
      `CHK(r, 32'hffff_fffc)
      `CHK(o_irq_level_five_n, 1'b1)
      $display("test timeout done");
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Hang guard, about three times the expected run
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         end_sim();
      end
   end

   // Main sequence
   initial begin
      cyc_n(20);
      i_rst <= 1'b0;
      t_reset();
      t_level0();
      t_serial();
      t_timers();
      t_coproc();
      t_fault();
      t_timeout();
      end_sim();
   end
endmodule
